// ### rtl/sec_err_regs.svh
// offsets, field positions, reset values of the secondary error flag register
`ifndef SEC_ERR_REGS_SVH
`define SEC_ERR_REGS_SVH

// register index as seen by the read port
`define SEF_OFFSET        7'h13

// field positions
`define SEF_HARD_RST_BIT  15
`define SEF_OCP_BIT       14
`define SEF_DESAT_BIT     13
`define SEF_UVLO_BIT      12
`define SEF_VERIFICATION_TIMEOUT_FLAG_BIT      9
`define SEF_ADC_OVER_BIT  6
`define SEF_ADC_UNDER_BIT 5
`define SEF_LINK_BIT      4
`define SEF_LMI_BIT       1
`define SEF_PARITY_BIT    0

// reserved ranges 11:10, 8:7 and 3:2
`define SEF_RES_MASK      16'h0D8C

// reset values: hard reset flag marks the power-up, the rest start clear
`define SEF_FLAGS_RESET   8'h01
`define SEF_LMI_RESET     1'b0

// number of sticky flags
`define SEF_NUM_FLAGS     8

`endif

// ### rtl/sec_err_pkg.sv
// types shared by the secondary error flag register
package sec_err_pkg;
   typedef logic [15:0] reg_word_t;
   typedef logic [7:0]  flag_vec_t;
   typedef logic [6:0]  reg_addr_t;
endpackage

// ### rtl/flag_cell.sv
// one sticky error flag with blockable clear
module flag_cell #(
   parameter logic RESET_VAL = 1'b0
) (
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic sys_rst_i,
   // control
   input  wire logic set_i,
   input  wire logic clr_i,
   input  wire logic block_i,
   // state
   output logic      flag_o
);
   logic flag_r;
   logic flag_nxt;

   // set wins over a clear in the same cycle so no event is lost
   always_comb begin
      flag_nxt = flag_r;
      if (clr_i && !block_i) begin
         flag_nxt = 1'b0;
      end
      if (set_i) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         flag_r <= RESET_VAL;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag_o = flag_r;
endmodule

// ### rtl/secondary_error_flags.sv
// secondary side error flag register with sticky flags and blocked clears
//
// Notes on behaviour
// [R01] hard reset flag set at secondary power-up reset and on detected hard reset
// [R02] overcurrent event sets bit 14, which stays set
// [R03] overcurrent flag cannot clear while comparator state is high
// [R04] desaturation event sets bit 13 and holds it until cleared
// [R05] gate supply undervoltage event sets bit 12, sticky
// [R06] undervoltage flag cannot clear while supply monitor reports failure
// [R07] verification mode time-out sets bit 9, sticky
// [R08] ADC upper boundary violation sets bit 6, sticky
// [R09] ADC lower boundary violation sets bit 5, sticky
// [R10] loss of primary link sets bit 4, sticky
// [R11] bit 1 shows whether the last message was discarded
// [R12] bit 0 makes the whole word odd parity
// [R13] bits 11:10, 8:7 and 3:2 read zero
// [R14] comparator state is the blanked synchronised overcurrent comparator output
// [R15] supply monitor output follows the live undervoltage monitor result
// [R16] flags hold until the host issues an accepted clear request
`include "sec_err_regs.svh"

module secondary_error_flags
   import sec_err_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       sys_rst_i,
   // detector event pulses, same clock
   input  wire logic       hard_reset_evt_i,
   input  wire logic       ocp_evt_i,
   input  wire logic       desat_evt_i,
   input  wire logic       uvlo_evt_i,
   input  wire logic       vm_timeout_evt_i,
   input  wire logic       adc_over_evt_i,
   input  wire logic       adc_under_evt_i,
   input  wire logic       link_loss_evt_i,
   // live analog levels, asynchronous
   input  wire logic       ocp_comp_raw_i,
   input  wire logic       uvlo_mon_raw_i,
   // overcurrent blanking window, same clock
   input  wire logic       ocp_blank_i,
   // message check result, same clock
   input  wire logic       msg_done_i,
   input  wire logic       msg_bad_i,
   // register read port
   input  wire logic       rd_req_i,
   input  wire reg_addr_t  rd_addr_i,
   output logic            rd_valid_o,
   output reg_word_t       rd_data_o,
   // clear request, write one to clear
   input  wire logic       clr_req_i,
   input  wire reg_word_t  clr_mask_i,
   // live status
   output logic            overcurrent_comparator_state_o,
   output logic            gate_supply_undervoltage_monitor_o
);
   // synchroniser stages for the analog comparator outputs
   logic ocp_meta_r;
   logic ocp_sync_r;
   logic uvlo_meta_r;
   logic uvlo_sync_r;

   // read port and message state
   logic      lmi_r;
   logic      lmi_nxt;
   logic      rd_valid_r;
   logic      rd_valid_nxt;
   reg_word_t rd_data_r;
   reg_word_t rd_data_nxt;

   // sticky flag wiring, index 0 is the hard reset flag
   flag_vec_t set_vec;
   flag_vec_t clr_vec;
   flag_vec_t block_vec;
   flag_vec_t flag_vec;
   reg_word_t word;
   logic      ocp_state;
   logic      uvlo_state;

   // two flip-flops before any logic reads the comparator levels
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ocp_meta_r  <= 1'b0;
         ocp_sync_r  <= 1'b0;
         uvlo_meta_r <= 1'b0;
         uvlo_sync_r <= 1'b0;
      end else begin
         ocp_meta_r  <= ocp_comp_raw_i;
         ocp_sync_r  <= ocp_meta_r;
         uvlo_meta_r <= uvlo_mon_raw_i;
         uvlo_sync_r <= uvlo_meta_r;
      end
   end

   // blanking hides switching spikes from the comparator state
   assign ocp_state  = ocp_sync_r & ~ocp_blank_i;  // R14
   assign uvlo_state = uvlo_sync_r;                // R15
   assign overcurrent_comparator_state_o     = ocp_state;
   assign gate_supply_undervoltage_monitor_o = uvlo_state;

   // event sources per flag
   assign set_vec[0] = hard_reset_evt_i;  // R01
   assign set_vec[1] = ocp_evt_i;         // R02
   assign set_vec[2] = desat_evt_i;       // R04
   assign set_vec[3] = uvlo_evt_i;        // R05
   assign set_vec[4] = vm_timeout_evt_i;  // R07
   assign set_vec[5] = adc_over_evt_i;    // R08
   assign set_vec[6] = adc_under_evt_i;   // R09
   assign set_vec[7] = link_loss_evt_i;   // R10

   // host clear bits picked out of the mask at each flag position
   assign clr_vec[0] = clr_req_i & clr_mask_i[`SEF_HARD_RST_BIT];   // R16
   assign clr_vec[1] = clr_req_i & clr_mask_i[`SEF_OCP_BIT];        // R16
   assign clr_vec[2] = clr_req_i & clr_mask_i[`SEF_DESAT_BIT];      // R16
   assign clr_vec[3] = clr_req_i & clr_mask_i[`SEF_UVLO_BIT];       // R16
   assign clr_vec[4] = clr_req_i & clr_mask_i[`SEF_VERIFICATION_TIMEOUT_FLAG_BIT];       // R16
   assign clr_vec[5] = clr_req_i & clr_mask_i[`SEF_ADC_OVER_BIT];   // R16
   assign clr_vec[6] = clr_req_i & clr_mask_i[`SEF_ADC_UNDER_BIT];  // R16
   assign clr_vec[7] = clr_req_i & clr_mask_i[`SEF_LINK_BIT];       // R16

   // a clear of the overcurrent or undervoltage flag is refused while that fault is still present
   assign block_vec = {4'h0, uvlo_state, 1'b0, ocp_state, 1'b0};  // R03 R06

   // one sticky cell per flag
   for (genvar g = 0; g < `SEF_NUM_FLAGS; g++) begin : g_flag
      localparam flag_vec_t RST_VEC = `SEF_FLAGS_RESET;
      flag_cell #(
         .RESET_VAL (RST_VEC[g])
      ) u_cell (
         .sys_clk_i (sys_clk_i),
         .sys_rst_i (sys_rst_i),
         .set_i     (set_vec[g]),
         .clr_i     (clr_vec[g]),
         .block_i   (block_vec[g]),
         .flag_o    (flag_vec[g])
      );
   end

   // register word, reserved bits tied low, parity closes the word
   always_comb begin
      word                      = 16'h0000;  // R13
      word[`SEF_HARD_RST_BIT]   = flag_vec[0];
      word[`SEF_OCP_BIT]        = flag_vec[1];
      word[`SEF_DESAT_BIT]      = flag_vec[2];
      word[`SEF_UVLO_BIT]       = flag_vec[3];
      word[`SEF_VERIFICATION_TIMEOUT_FLAG_BIT]       = flag_vec[4];
      word[`SEF_ADC_OVER_BIT]   = flag_vec[5];
      word[`SEF_ADC_UNDER_BIT]  = flag_vec[6];
      word[`SEF_LINK_BIT]       = flag_vec[7];
      word[`SEF_LMI_BIT]        = lmi_r;  // R11
      word[`SEF_PARITY_BIT]     = ~(^word[15:1]);  // R12
   end

   // last message status and read capture
   always_comb begin
      lmi_nxt      = lmi_r;
      rd_valid_nxt = rd_req_i;
      rd_data_nxt  = rd_data_r;
      if (msg_done_i) begin
         lmi_nxt = msg_bad_i;  // R11
      end
      // unmapped address answers with an all-zero word
      if (rd_req_i) begin
         rd_data_nxt = (rd_addr_i == `SEF_OFFSET) ? word : 16'h0000;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         lmi_r      <= `SEF_LMI_RESET;
         rd_valid_r <= 1'b0;
         rd_data_r  <= 16'h0000;
      end else begin
         lmi_r      <= lmi_nxt;
         rd_valid_r <= rd_valid_nxt;
         rd_data_r  <= rd_data_nxt;
      end
   end

   assign rd_valid_o = rd_valid_r;
   assign rd_data_o  = rd_data_r;

   // checks next to the logic they guard
   chk_hard_rst_set: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // R01
      hard_reset_evt_i |=> word[`SEF_HARD_RST_BIT])
      else $error("hard reset flag not set after event");

   chk_ocp_sticks: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // R02
      ocp_evt_i ##1 !clr_req_i |=> word[`SEF_OCP_BIT])
      else $error("overcurrent flag lost without clear");

   chk_ocp_clear_block: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // R03
      word[`SEF_OCP_BIT] && ocp_state |=> word[`SEF_OCP_BIT])
      else $error("overcurrent flag cleared while comparator active");

   chk_desat_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // R04
      clr_req_i && clr_mask_i[`SEF_DESAT_BIT] && !desat_evt_i
      |=> !word[`SEF_DESAT_BIT])
      else $error("desaturation flag not cleared on request");

   chk_uvlo_clear_block: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // R06
      word[`SEF_UVLO_BIT] && uvlo_state |=> word[`SEF_UVLO_BIT])
      else $error("undervoltage flag cleared while monitor active");

   chk_flags_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // R16
      !clr_req_i |=> (flag_vec & $past(flag_vec)) == $past(flag_vec))
      else $error("sticky flag dropped without clear");

   // an event meeting a clear on the same edge must still leave its flag set
   chk_set_wins: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // R16
      set_vec != 8'h00 |=> (flag_vec & $past(set_vec)) == $past(set_vec))
      else $error("event lost against a same cycle clear");

   chk_link_set: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // R10
      link_loss_evt_i |=> word[`SEF_LINK_BIT] ##1 (word[`SEF_LINK_BIT] || $past(clr_req_i)))
      else $error("link loss flag not held");

   chk_lmi_follow: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // R11
      msg_done_i |=> lmi_r == $past(msg_bad_i))
      else $error("last message status wrong");

   chk_read_parity: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // R12
      rd_req_i && rd_addr_i == `SEF_OFFSET |=> rd_valid_o && ^rd_data_o
      && rd_data_o == $past(word))
      else $error("read word wrong or parity even");

   chk_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // R13
      rd_valid_o |-> (rd_data_o & `SEF_RES_MASK) == 16'h0000)
      else $error("reserved bits read nonzero");

   chk_ocp_blank: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // R14
      ocp_blank_i |-> !overcurrent_comparator_state_o)
      else $error("comparator state visible during blanking");

   chk_adc_set: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)  // R08 R09
      adc_over_evt_i && adc_under_evt_i |=> word[6:5] == 2'b11)
      else $error("adc boundary flags not set");
endmodule

// ### testbench/host_model.sv
// host model issuing register reads and write-one-to-clear requests
module host_model
   import sec_err_pkg::*;
(
   // clock
   input  wire logic      sys_clk_i,
   // read answer
   input  wire logic      rd_valid_i,
   input  wire reg_word_t rd_data_i,
   // requests
   output logic           rd_req_o,
   output reg_addr_t      rd_addr_o,
   output logic           clr_req_o,
   output reg_word_t      clr_mask_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle at time zero
   initial begin
      rd_req_o = 1'b0;
      rd_addr_o = 7'h00;
      clr_req_o = 1'b0;
      clr_mask_o = 16'h0000;
   end

   // one read, answer sampled mid-cycle after the taking edge
   task automatic read(input reg_addr_t a, output logic v, output reg_word_t d);
      @(negedge sys_clk_i);
      rd_req_o = 1'b1;
      rd_addr_o = a;
      @(negedge sys_clk_i);
      rd_req_o = 1'b0;
      rd_addr_o = ~a; // released address never shows a stale value
      v = rd_valid_i;
      d = rd_data_i;
   endtask

   // explicit clear request, the only way besides reset that a sticky flag goes away
   task automatic clear(input reg_word_t m);
      @(negedge sys_clk_i);
      clr_req_o = 1'b1;
      clr_mask_o = m;
      @(negedge sys_clk_i);
      clr_req_o = 1'b0;
      clr_mask_o = ~m;
   endtask
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the secondary error flag register
module tb_top
   import sec_err_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end

   // stimulus and observed signals
   logic      sys_clk_i, sys_rst_i, ocp_raw, uvlo_raw, blank, msg_done, msg_bad;
   logic      rd_req, rd_valid, clr_req, ocp_state, uvlo_mon, v;
   flag_vec_t evt;
   reg_addr_t rd_addr;
   reg_word_t rd_data, clr_mask, w;
   int        err_total = 0;
   int        checked = 0;
   int        cyc = 0;

   // one event per row, the word it should leave behind
   typedef struct packed {flag_vec_t evt; reg_word_t exp;} row_t;
   row_t rows[8] = '{'{8'h80, 16'h8000}, '{8'h40, 16'h4000}, '{8'h20, 16'h2000},
      '{8'h10, 16'h1000}, '{8'h08, 16'h0200}, '{8'h04, 16'h0040}, '{8'h02, 16'h0020},
      '{8'h01, 16'h0010}};

   secondary_error_flags secondary_error_flags_i (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .hard_reset_evt_i(evt[7]), .ocp_evt_i(evt[6]), .desat_evt_i(evt[5]),
      .uvlo_evt_i(evt[4]), .vm_timeout_evt_i(evt[3]), .adc_over_evt_i(evt[2]),
      .adc_under_evt_i(evt[1]), .link_loss_evt_i(evt[0]),
      .ocp_comp_raw_i(ocp_raw), .uvlo_mon_raw_i(uvlo_raw), .ocp_blank_i(blank),
      .msg_done_i(msg_done), .msg_bad_i(msg_bad),
      .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_valid_o(rd_valid), .rd_data_o(rd_data),
      .clr_req_i(clr_req), .clr_mask_i(clr_mask),
      .overcurrent_comparator_state_o(ocp_state),
      .gate_supply_undervoltage_monitor_o(uvlo_mon));

   host_model host_model_i (
      .sys_clk_i(sys_clk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
      .rd_req_o(rd_req), .rd_addr_o(rd_addr), .clr_req_o(clr_req), .clr_mask_o(clr_mask));

   // 50 ns clock
   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   // hang guard, the whole run needs well under a thousand cycles
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      $display("counts: checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic rdx(input reg_addr_t a, input reg_word_t e);
      host_model_i.read(a, v, w);
      `CHK("valid", 1'b1, v)
      `CHK("word", e, w)
   endtask

   task automatic pulse_evt(input flag_vec_t e);
      @(negedge sys_clk_i);
      evt = e;
      @(negedge sys_clk_i);
      evt = 8'h00;
   endtask

   // live levels pass a two-flop synchroniser, four cycles is ample
   task automatic settle;
      repeat (4) @(negedge sys_clk_i);
   endtask

   // live levels and blanking change together, never mid-check
   task automatic drive_lvl(input logic oc, input logic uv, input logic bl);
      ocp_raw = oc;
      uvlo_raw = uv;
      blank = bl;
   endtask

   // one checked message; the status bit must ignore it once done drops
   task automatic send_msg(input logic bad);
      @(negedge sys_clk_i);
      msg_done = 1'b1;
      msg_bad = bad;
      @(negedge sys_clk_i);
      msg_done = 1'b0;
      msg_bad = ~bad;
   endtask

   // main sequence
   initial begin
      sys_rst_i = 1'b1;
      drive_lvl(1'b0, 1'b0, 1'b0);
      msg_done = 1'b0;
      msg_bad = 1'b0;
      evt = 8'h00;
      repeat (10) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      rdx(7'h13, 16'h8000);
      rdx(7'h00, 16'h0000);
      host_model_i.clear(16'hFFFF);
      rdx(7'h13, 16'h0001);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         pulse_evt(rows[i].evt);
         settle();
         rdx(7'h13, rows[i].exp);
         host_model_i.clear(rows[i].exp);
         rdx(7'h13, 16'h0001);
      end
      $display("test events done");
      pulse_evt(8'hFF);
      host_model_i.clear(16'h0D8F);
      rdx(7'h13, 16'hF271);
      host_model_i.clear(16'hFFFF);
      $display("test reserved done");
      drive_lvl(1'b1, 1'b0, 1'b0);
      settle();
      `CHK("ocp_state", 1'b1, ocp_state)
      pulse_evt(8'h40);
      host_model_i.clear(16'h4000);
      rdx(7'h13, 16'h4000);
      drive_lvl(1'b1, 1'b0, 1'b1);
      @(negedge sys_clk_i);
      `CHK("ocp_state", 1'b0, ocp_state)
      drive_lvl(1'b0, 1'b0, 1'b0);
      settle();
      host_model_i.clear(16'h4000);
      rdx(7'h13, 16'h0001);
      drive_lvl(1'b0, 1'b1, 1'b0);
      settle();
      `CHK("uvlo_mon", 1'b1, uvlo_mon)
      pulse_evt(8'h10);
      host_model_i.clear(16'h1000);
      rdx(7'h13, 16'h1000);
      drive_lvl(1'b0, 1'b0, 1'b0);
      settle();
      `CHK("uvlo_mon", 1'b0, uvlo_mon)
      host_model_i.clear(16'h1000);
      rdx(7'h13, 16'h0001);
      $display("test blocked clears done");
      send_msg(1'b1);
      rdx(7'h13, 16'h0002);
      send_msg(1'b0);
      rdx(7'h13, 16'h0001);
      $display("test message status done");
      // event and clear meet on one edge, the event has to win
      fork
         pulse_evt(8'h20);
         host_model_i.clear(16'h2000);
      join
      rdx(7'h13, 16'h2000);
      host_model_i.clear(16'h2000);
      rdx(7'h13, 16'h0001);
      $display("test set wins done");
      // mid-run reset drops every flag and status back to the power-up word
      pulse_evt(8'h41);
      send_msg(1'b1);
      rdx(7'h13, 16'h4012);
      @(negedge sys_clk_i);
      sys_rst_i = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      rdx(7'h13, 16'h8000);
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule
